// *** ddwf_assertions.sv ***
// concurrent checks on the link between user end and controller end
// assumes the bench instantiates it beside the ddwf_if that joins them
`timescale 1ns/1ps
module ddwf_chk
  import ddwf_pkg::*;
#(
  parameter int MEM_W = MEM_W_DEF
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // user pushes
  input wire logic cmd_fifo_push,
  input wire logic [CA_W-1:0] cmd_addr_word,
  input wire logic wdf_push,
  input wire logic [2*MEM_W-1:0] wdf_data,
  input wire logic [2*MEM_W/BITS_PER_MASK-1:0] wdf_mask,
  // controller status
  input wire logic cmd_fifo_full,
  input wire logic cmd_fifo_nearly_full,
  input wire logic wdf_full,
  input wire logic wdf_nearly_full,
  input wire logic rd_valid,
  input wire logic calib_done
);
  // ************************************************************
  // properties, all in the one clock domain
  // ************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  a_quiet_before_cal: assert property (
    !calib_done |-> !cmd_fifo_push && !wdf_push) else $error("push before calibration");
  a_low_data_precal: assert property (
    !calib_done |-> wdf_data == '0 && wdf_mask == '0) else $error("data not low in calibration");
  a_wdata_within_two: assert property (
    cmd_fifo_push && cmd_addr_word[34:32] == CMD_WRITE |-> ##[0:2] wdf_push)
    else $error("write data late");
  a_rsvd_bit_clear: assert property (
    cmd_fifo_push |-> !cmd_addr_word[CA_RSVD_BIT]) else $error("reserved bit set");
  a_full_has_near: assert property (
    (cmd_fifo_full |-> cmd_fifo_nearly_full) and (wdf_full |-> wdf_nearly_full))
    else $error("full without nearly full");
  a_flags_low_reset: assert property (
    $past(SRST) |-> !cmd_fifo_full && !wdf_full && !calib_done) else $error("flag up at reset");
  a_cal_done_holds: assert property (
    calib_done |=> calib_done) else $error("calibration done dropped");
  // the push leaves one cycle after the take, so the flags one cycle back decide
  a_push_when_free: assert property (
    cmd_fifo_push |-> !$past(cmd_fifo_full) && !$past(wdf_full)) else $error("push into full");
  a_read_answered: assert property (
    cmd_fifo_push && cmd_addr_word[34:32] == CMD_READ |-> ##[3:80] rd_valid)
    else $error("read not answered");
  a_rd_one_cycle: assert property (
    rd_valid |=> !rd_valid) else $error("read valid too long");
endmodule

// *** ddwf_dev.sv ***
// controller end: command/address fifo, write data fifo, calibration and pop order
// ignores user pushes on ddwf_if until calibration completes
//
// What this block and the user end do
// - command, write data and read buses
// - user pushes nothing before calibration done
// - user holds pushes, data, mask low meanwhile
// - write data fifo holds training patterns
// - first write data within two cycles
// - elements 512 deep, 32 data plus 4 mask
// - mask path only when masking enabled
// - one command fifo for reads and writes
// - user word twice memory width, mask per byte
// - 8-bit width uses low bits, zero padded
// - widths over 16 bits use parallel fifo elements
// - full flags follow each fifo
// - full flags low from power-on
// - writes start only with both flags low
// - data and mask pushed together
// - pop command first, then write data
// - command field codes in bits 34 to 32
// - rising half high, falling half low
`timescale 1ns/1ps

// ************************************************************
// one fifo element
// ************************************************************
module ddwf_fifo
  import ddwf_pkg::*;
#(
  parameter int W = ELEM_DPORT_W + ELEM_MPORT_W,
  parameter int DEPTH = ELEM_DEPTH,
  parameter int AW = ELEM_AW,
  parameter int MARGIN = CMD_NEAR_MARGIN
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  output logic [W-1:0] rdata,
  output logic empty,
  output logic full,
  output logic nearly_full
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic do_push;
  logic do_pop;

  // a push into a full element or a pop from an empty one is dropped
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign cnt_d = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
  assign rdata = mem[rd_q];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_q] <= wdata;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_q + AW'(do_push);
      rd_q <= rd_q + AW'(do_pop);
      cnt_q <= cnt_d;
    end
  end

  // flags are flops taken from the next count so they match the contents
  always_ff @(posedge clk) begin
    if (rst) begin
      empty <= 1'b1;
      full <= 1'b0;
      nearly_full <= 1'b0;
    end else begin
      empty <= cnt_d == '0;
      full <= cnt_d == (AW+1)'(DEPTH);
      nearly_full <= cnt_d >= (AW+1)'(DEPTH - MARGIN);
    end
  end
endmodule

// ************************************************************
// controller end
// ************************************************************
module ddwf_dev
  import ddwf_pkg::*;
#(
  parameter int MEM_W = MEM_W_DEF,
  parameter bit MASK_EN = 1'b1,
  parameter int LOOP_AW = LOOP_AW_DEF
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // memory-side command report
  output logic MEM_OP_VALID,
  output logic [CA_CMD_W-1:0] MEM_OP_CODE,
  output logic [CA_ADDR_W-1:0] MEM_OP_ADDR,
  output logic CAL_ERROR,
  // user side
  ddwf_if.dev bus
);
  localparam int DW = 2 * MEM_W;
  localparam int MW = DW / BITS_PER_MASK;
  localparam int HMW = MW / 2;
  localparam int NE = (MEM_W + ELEM_HALF_W - 1) / ELEM_HALF_W;
  localparam int EW = ELEM_DPORT_W + ELEM_MPORT_W;

  typedef enum logic [2:0] {
    ST_CALW = 3'h0,
    ST_CALR = 3'h1,
    ST_IDLE = 3'h2,
    ST_DEC = 3'h3,
    ST_WDAT = 3'h4
  } ddwf_state_t;

  ddwf_state_t st_q;
  logic [CA_W-1:0] cmd_rdata;
  logic cmd_empty;
  logic cmd_pop;
  logic [CA_W-1:0] cmd_q;
  logic wdf_push;
  logic wdf_pop;
  logic [DW-1:0] wdf_in_data;
  logic [MW-1:0] wdf_in_mask;
  logic [DW-1:0] wdf_out_data;
  logic [MW-1:0] wdf_out_mask;
  logic [NE-1:0] e_empty;
  logic [NE-1:0] e_full;
  logic [NE-1:0] e_nfull;
  logic [2:0] cal_cnt_q;
  logic cal_err_q;
  logic done_q;
  logic [DW+MW-1:0] store [2**LOOP_AW];
  logic [DW-1:0] rd_data_q;
  logic rd_valid_q;
  logic op_valid_q;
  logic [CA_CMD_W-1:0] op_code_q;
  logic [CA_ADDR_W-1:0] op_addr_q;
  logic [DW-1:0] cal_pat;
  logic [LOOP_AW-1:0] cmd_slot;

  // training pattern alternates per word so stuck bits show up
  assign cal_pat = cal_cnt_q[0] ? {(DW/2){2'h1}} : {(DW/2){2'h2}};
  assign cmd_slot = cmd_q[LOOP_AW-1:0];

  // ************************************************************
  // command/address fifo, shared by reads and writes
  // ************************************************************
  ddwf_fifo #(.W(CA_W), .MARGIN(CMD_NEAR_MARGIN)) u_cmd (
    .clk(SYS_CLK),
    .rst(SRST),
    .push(bus.cmd_fifo_push & done_q),
    .wdata(bus.cmd_addr_word),
    .pop(cmd_pop),
    .rdata(cmd_rdata),
    .empty(cmd_empty),
    .full(bus.cmd_fifo_full),
    .nearly_full(bus.cmd_fifo_nearly_full)
  );

  // ************************************************************
  // write data fifo: calibration owns it until done
  // ************************************************************
  // user pushes are ignored before done so stray writes cannot spoil training
  assign wdf_push = done_q ? bus.wdf_push : (st_q == ST_CALW && cal_cnt_q < 3'(CAL_WORDS));
  assign wdf_in_data = done_q ? bus.wdf_data : cal_pat;
  assign wdf_in_mask = (done_q && MASK_EN) ? bus.wdf_mask : '0;

  // each element: rise and fall slices zero padded into the 32-bit port
  for (genvar e = 0; e < NE; e++) begin : g_elem
    localparam int SW = (MEM_W - ELEM_HALF_W*e) >= ELEM_HALF_W ? ELEM_HALF_W
                        : MEM_W - ELEM_HALF_W*e;
    localparam int SM = SW / BITS_PER_MASK;
    logic [EW-1:0] din;
    logic [EW-1:0] dout;
    assign din[ELEM_DPORT_W-1:0] = ELEM_DPORT_W'({
      wdf_in_data[MEM_W + ELEM_HALF_W*e +: SW], wdf_in_data[ELEM_HALF_W*e +: SW]});
    assign din[EW-1:ELEM_DPORT_W] = ELEM_MPORT_W'({
      wdf_in_mask[HMW + 2*e +: SM], wdf_in_mask[2*e +: SM]});
    assign wdf_out_data[MEM_W + ELEM_HALF_W*e +: SW] = dout[SW +: SW];
    assign wdf_out_data[ELEM_HALF_W*e +: SW] = dout[0 +: SW];
    assign wdf_out_mask[HMW + 2*e +: SM] = dout[ELEM_DPORT_W + SM +: SM];
    assign wdf_out_mask[2*e +: SM] = dout[ELEM_DPORT_W +: SM];
    ddwf_fifo #(.W(EW), .MARGIN(WDF_NEAR_MARGIN)) u_wdf (
      .clk(SYS_CLK),
      .rst(SRST),
      .push(wdf_push),
      .wdata(din),
      .pop(wdf_pop),
      .rdata(dout),
      .empty(e_empty[e]),
      .full(e_full[e]),
      .nearly_full(e_nfull[e])
    );
  end

  // elements move in lockstep, so element 0 speaks for all
  assign bus.wdf_full = e_full[0];
  assign bus.wdf_nearly_full = e_nfull[0];

  // ************************************************************
  // pop order
  // ************************************************************
  assign cmd_pop = (st_q == ST_IDLE) & ~cmd_empty;
  assign wdf_pop = ((st_q == ST_WDAT) | (st_q == ST_CALR)) & ~e_empty[0];

  // sequencer: calibration, then command first, data only after decode
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      st_q <= ST_CALW;
      cal_cnt_q <= '0;
    end else begin
      unique case (st_q)
        ST_CALW: begin
          cal_cnt_q <= cal_cnt_q + 3'h1;
          if (cal_cnt_q == 3'(CAL_WORDS - 1)) begin
            st_q <= ST_CALR;
          end
        end
        ST_CALR: begin
          if (!e_empty[0]) begin
            cal_cnt_q <= cal_cnt_q - 3'h1;
          end
          if (cal_cnt_q == 3'h1 && !e_empty[0]) begin
            st_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (cmd_pop) begin
            st_q <= ST_DEC;
          end
        end
        ST_DEC: begin
          st_q <= (cmd_q[CA_CMD_LSB +: CA_CMD_W] == CMD_WRITE) ? ST_WDAT : ST_IDLE;
        end
        ST_WDAT: begin
          // user has at most two cycles to land the data, so waiting is short
          if (!e_empty[0]) begin
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // latch the popped command word for decode
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      cmd_q <= '0;
    end else if (cmd_pop) begin
      cmd_q <= cmd_rdata;
    end
  end

  // calibration check: training words read back in push order
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      cal_err_q <= 1'b0;
      done_q <= 1'b0;
    end else if (st_q == ST_CALR && !e_empty[0]) begin
      if (wdf_out_data != cal_pat) begin // push and pop counts share parity
        cal_err_q <= 1'b1;
      end
      if (cal_cnt_q == 3'h1) begin
        done_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // stand-in store and read return
  // ************************************************************
  always_ff @(posedge SYS_CLK) begin
    if (st_q == ST_WDAT && !e_empty[0]) begin
      store[cmd_slot] <= {wdf_out_mask, wdf_out_data};
    end
  end

  // one read word per read command, one cycle after decode
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      rd_valid_q <= (st_q == ST_DEC) && cmd_q[CA_CMD_LSB +: CA_CMD_W] == CMD_READ;
      if (st_q == ST_DEC && cmd_q[CA_CMD_LSB +: CA_CMD_W] == CMD_READ) begin
        rd_data_q <= store[cmd_slot][DW-1:0];
      end
    end
  end

  // memory-side report: every decoded command, invalid codes included
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      op_valid_q <= 1'b0;
      op_code_q <= '0;
      op_addr_q <= '0;
    end else begin
      op_valid_q <= st_q == ST_DEC;
      if (st_q == ST_DEC) begin
        op_code_q <= cmd_q[CA_CMD_LSB +: CA_CMD_W];
        op_addr_q <= cmd_q[CA_ADDR_W-1:0];
      end
    end
  end

  assign bus.rd_data = rd_data_q;
  assign bus.rd_valid = rd_valid_q;
  assign bus.calib_done = done_q;
  assign MEM_OP_VALID = op_valid_q;
  assign MEM_OP_CODE = op_code_q;
  assign MEM_OP_ADDR = op_addr_q;
  assign CAL_ERROR = cal_err_q;
endmodule

// *** ddwf_if.sv ***
// interface joining user logic to the controller's fifo front end
// assumes both ends share the same clock and reset
`timescale 1ns/1ps
interface ddwf_if #(
  parameter int MEM_W = ddwf_pkg::MEM_W_DEF
);
  import ddwf_pkg::*;
  localparam int DW = 2 * MEM_W;
  localparam int MW = DW / BITS_PER_MASK;
  // command/address fifo
  logic cmd_fifo_push;
  logic [CA_W-1:0] cmd_addr_word;
  logic cmd_fifo_full;
  logic cmd_fifo_nearly_full;
  // write data fifo
  logic wdf_push;
  logic [DW-1:0] wdf_data;
  logic [MW-1:0] wdf_mask;
  logic wdf_full;
  logic wdf_nearly_full;
  // read bus and status
  logic [DW-1:0] rd_data;
  logic rd_valid;
  logic calib_done;
  modport dev (
    input cmd_fifo_push, cmd_addr_word, wdf_push, wdf_data, wdf_mask,
    output cmd_fifo_full, cmd_fifo_nearly_full, wdf_full, wdf_nearly_full,
    output rd_data, rd_valid, calib_done
  );
  modport usr (
    output cmd_fifo_push, cmd_addr_word, wdf_push, wdf_data, wdf_mask,
    input cmd_fifo_full, cmd_fifo_nearly_full, wdf_full, wdf_nearly_full,
    input rd_data, rd_valid, calib_done
  );
endinterface

// *** ddwf_pkg.sv ***
// shared constants for the user write front end of a ddr2 controller
// assumes one clock domain and a synchronous active-high reset
package ddwf_pkg;
  // ************************************************************
  // geometry of the fifo elements
  // ************************************************************
  localparam int MEM_W_DEF = 8;        // memory data width, bits
  localparam int ELEM_DEPTH = 512;     // entries per fifo element
  localparam int ELEM_AW = 9;          // log2 of the depth
  localparam int ELEM_DPORT_W = 32;    // data port of one element
  localparam int ELEM_MPORT_W = 4;     // mask port of one element
  localparam int ELEM_HALF_W = 16;     // rise or fall data per element
  localparam int BITS_PER_MASK = 8;    // data bits covered by one mask bit
  localparam int CMD_NEAR_MARGIN = 8;  // pushes still allowed after nearly-full
  localparam int WDF_NEAR_MARGIN = 14; // same for the write data fifo
  // ************************************************************
  // command/address word
  // ************************************************************
  localparam int CA_W = 36;
  localparam int CA_ADDR_W = 32;
  localparam int CA_CMD_LSB = 32;
  localparam int CA_CMD_W = 3;
  localparam int CA_RSVD_BIT = 35;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  // ************************************************************
  // timing and calibration
  // ************************************************************
  localparam int WR_DATA_LAG_CYC = 2;  // latest cycle of first data after a write
  localparam int CAL_WORDS = 4;        // training words pushed and checked
  localparam int LOOP_AW_DEF = 4;      // address bits of the stand-in store
endpackage

// *** ddwf_tb.sv ***
// self-checking bench: user end against controller end, plus a raw driver
// assumes ddwf_pkg, ddwf_if, ddwf_usr, ddwf_dev and ddwf_chk are compiled first
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("ERROR %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module ddwf_tb;
  import ddwf_pkg::*;
  // ************************************************************
  // signals and instances
  // ************************************************************
  localparam int MW = 24; // three bytes, so two data elements side by side
  localparam int DW = 2 * MW;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic usr_req, usr_ready, usr_rvalid, usr_cal_done, op_valid, cal_err;
  logic op_valid_b, cal_err_b;
  logic [2:0] usr_cmd, op_code, last_c;
  logic [31:0] usr_addr, op_addr, last_a, rng = 32'h53;
  logic [DW-1:0] usr_wdata, usr_rdata, last_d, rd_e;
  logic [DW/8-1:0] usr_wmask, last_m;
  logic [34:0] op_e;
  logic [DW-1:0] mem [16];
  logic [34:0] op_q[$];
  logic [DW-1:0] rd_q[$];
  logic [15:0] b_rd;
  int n_fail = 0, checks = 0, cyc = 0, b_ops = 0;
  ddwf_if #(.MEM_W(MW)) aif();
  ddwf_if #(.MEM_W(8)) bif();
  ddwf_usr #(.MEM_W(MW)) u_ddwf_usr (.SYS_CLK(sys_clk), .SRST(srst), .USR_REQ(usr_req),
    .USR_CMD(usr_cmd), .USR_ADDR(usr_addr), .USR_WDATA(usr_wdata), .USR_WMASK(usr_wmask),
    .USR_READY(usr_ready), .USR_RDATA(usr_rdata), .USR_RVALID(usr_rvalid),
    .USR_CAL_DONE(usr_cal_done), .bus(aif.usr));
  ddwf_dev #(.MEM_W(MW)) u_ddwf_dev (.SYS_CLK(sys_clk), .SRST(srst), .MEM_OP_VALID(op_valid),
    .MEM_OP_CODE(op_code), .MEM_OP_ADDR(op_addr), .CAL_ERROR(cal_err), .bus(aif.dev));
  // second controller end, fed by a raw driver that may break the user rules
  ddwf_dev u_ddwf_dev_b (.SYS_CLK(sys_clk), .SRST(srst), .MEM_OP_VALID(op_valid_b),
    .MEM_OP_CODE(), .MEM_OP_ADDR(), .CAL_ERROR(cal_err_b), .bus(bif.dev));
  ddwf_chk #(.MEM_W(MW)) u_ddwf_chk (.SYS_CLK(sys_clk), .SRST(srst),
    .cmd_fifo_push(aif.cmd_fifo_push), .cmd_addr_word(aif.cmd_addr_word),
    .wdf_push(aif.wdf_push), .wdf_data(aif.wdf_data), .wdf_mask(aif.wdf_mask),
    .cmd_fifo_full(aif.cmd_fifo_full), .cmd_fifo_nearly_full(aif.cmd_fifo_nearly_full),
    .wdf_full(aif.wdf_full), .wdf_nearly_full(aif.wdf_nearly_full),
    .rd_valid(aif.rd_valid), .calib_done(aif.calib_done));
  // ************************************************************
  // clock, helpers, monitors
  // ************************************************************
  always #50 sys_clk = ~sys_clk;
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // a hang is cut short well beyond the 1500 or so cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  // sampled on the falling edge, where registered outputs have settled
  always @(negedge sys_clk) begin
    if (op_valid === 1'b1) begin
      op_e = op_q.size() ? op_q.pop_front() : 35'h7FFFFFFFF;
      `CHK("mem op", op_e, {op_code, op_addr})
    end
    if (usr_rvalid === 1'b1) begin
      rd_e = rd_q.size() ? rd_q.pop_front() : ~usr_rdata;
      `CHK("read data", rd_e, usr_rdata)
    end
    if (aif.cmd_fifo_push === 1'b1) `CHK("cmd word", {1'b0, last_c, last_a}, aif.cmd_addr_word)
    if (aif.wdf_push === 1'b1) `CHK("wdf data", last_d, aif.wdf_data)
    if (aif.wdf_push === 1'b1) `CHK("wdf mask", last_m, aif.wdf_mask)
    if (op_valid_b === 1'b1) b_ops++;
    if (bif.rd_valid === 1'b1) b_rd = bif.rd_data;
  end
  // one request through the user end; holds it until ready lets it in
  task automatic req(input logic [2:0] c, input logic [31:0] a, input logic [DW-1:0] d);
    int n = 0;
    @(posedge sys_clk);
    last_c = c;
    last_a = a;
    last_d = d;
    usr_req <= 1'b1;
    usr_cmd <= c;
    usr_addr <= a;
    usr_wdata <= d;
    last_m = (DW/8)'(rnd());
    usr_wmask <= last_m;
    #1;
    while (usr_ready !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    usr_req <= 1'b0;
    op_q.push_back({c, a});
    if (c == CMD_WRITE) mem[a[3:0]] = d;
    if (c == CMD_READ) rd_q.push_back(mem[a[3:0]]);
    `CHK("ready", 1'b1, n < 200)
  endtask
  task automatic drain();
    int n = 0;
    while ((op_q.size() != 0 || rd_q.size() != 0) && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("drained", 1'b1, n < 400)
  endtask
  // raw driver for the second controller end
  task automatic bdrv(input logic cp, input logic [35:0] w, input logic dp, input logic [15:0] d);
    @(posedge sys_clk);
    bif.cmd_fifo_push <= cp;
    bif.cmd_addr_word <= w;
    bif.wdf_push <= dp;
    bif.wdf_data <= d;
    #1;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [63:0] r;
    logic [31:0] a;
    logic [2:0] ops [4];
    int n;
    ops = '{CMD_WRITE, CMD_READ, CMD_REFRESH, CMD_PRECHARGE};
    usr_req = 1'b0;
    usr_cmd = '0;
    usr_addr = '0;
    usr_wdata = '0;
    usr_wmask = '0;
    bif.cmd_fifo_push = 1'b0;
    bif.cmd_addr_word = '0;
    bif.wdf_push = 1'b0;
    bif.wdf_data = '0;
    bif.wdf_mask = '0;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    // pushes during calibration must be ignored by the controller end
    bdrv(1'b1, {1'b0, CMD_WRITE, 32'h5}, 1'b1, 16'hFFFF);
    `CHK("cmd full rst", 1'b0, aif.cmd_fifo_full)
    `CHK("wdf full rst", 1'b0, aif.wdf_full)
    bdrv(1'b0, '0, 1'b0, '0);
    n = 0;
    while (usr_cal_done !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("cal done", 1'b1, usr_cal_done)
    `CHK("cal error", 1'b0, cal_err)
    `CHK("early ops", 0, b_ops)
    $display("test calibration done");
    // every slot written back to back, corners first
    req(CMD_WRITE, 32'hFFFFFFFF, {DW{1'b1}});
    req(CMD_WRITE, 32'h0, '0);
    for (int i = 1; i < 15; i++) begin
      r = {rnd(), rnd()};
      a = rnd();
      a[3:0] = i[3:0];
      req(CMD_WRITE, a, r[DW-1:0]);
    end
    req(CMD_REFRESH, rnd(), '0);
    req(CMD_PRECHARGE, rnd(), '0);
    drain();
    $display("test writes done");
    for (int i = 15; i >= 0; i--) req(CMD_READ, {rnd() & 32'hFFFFFFF0} | i, '0);
    drain();
    $display("test reads done");
    for (int i = 0; i < 24; i++) begin
      r = {rnd(), rnd()};
      req(ops[rnd() % 4], rnd(), r[DW-1:0]);
    end
    drain();
    $display("test random mix done");
    // narrow end: rise byte high, fall byte low in the low half of the port
    n = 0;
    while (bif.calib_done !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    bdrv(1'b1, {1'b0, CMD_WRITE, 32'h3}, 1'b1, 16'hA53C);
    bdrv(1'b0, '0, 1'b0, '0);
    repeat (8) bdrv(1'b0, '0, 1'b0, '0);
    bdrv(1'b1, {1'b0, CMD_READ, 32'h3}, 1'b0, '0);
    bdrv(1'b0, '0, 1'b0, '0);
    repeat (12) bdrv(1'b0, '0, 1'b0, '0);
    `CHK("narrow read", 16'hA53C, b_rd)
    `CHK("narrow ops", 2, b_ops)
    `CHK("cal error b", 1'b0, cal_err_b)
    $display("test narrow width done");
    // writes without data stall the controller, so the command fifo fills
    for (n = 0; n < 600 && bif.cmd_fifo_full !== 1'b1; n++) bdrv(1'b1, {4'h4, 32'h0}, 1'b0, '0);
    `CHK("cmd full", 1'b1, bif.cmd_fifo_full)
    `CHK("cmd near", 1'b1, bif.cmd_fifo_nearly_full)
    for (n = 0; n < 1000 && bif.wdf_full !== 1'b1; n++) bdrv(1'b0, '0, 1'b1, n[15:0]);
    `CHK("wdf full", 1'b1, bif.wdf_full)
    bdrv(1'b0, '0, 1'b0, '0);
    $display("test overflow done");
    end_of_test();
  end
endmodule

// *** ddwf_usr.sv ***
// user backend end: turns plain requests into fifo pushes
// assumes the controller end answers through ddwf_if on the same clock
`timescale 1ns/1ps
module ddwf_usr
  import ddwf_pkg::*;
#(
  parameter int MEM_W = MEM_W_DEF
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // request side
  input wire logic USR_REQ,
  input wire logic [CA_CMD_W-1:0] USR_CMD,
  input wire logic [CA_ADDR_W-1:0] USR_ADDR,
  input wire logic [2*MEM_W-1:0] USR_WDATA,
  input wire logic [2*MEM_W/BITS_PER_MASK-1:0] USR_WMASK,
  output logic USR_READY,
  // answer side
  output logic [2*MEM_W-1:0] USR_RDATA,
  output logic USR_RVALID,
  output logic USR_CAL_DONE,
  // controller
  ddwf_if.usr bus
);
  localparam int DW = 2 * MEM_W;
  localparam int MW = DW / BITS_PER_MASK;
  logic ready_q;
  logic take;
  logic [DW-1:0] rdata_q;
  logic rvalid_q;
  logic cal_q;

  // ************************************************************
  // acceptance
  // ************************************************************
  // nearly-full is used as well as full: flags lag our own push by one edge
  assign take = USR_REQ & ready_q;
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= bus.calib_done & ~bus.cmd_fifo_nearly_full & ~bus.wdf_nearly_full
        & ~bus.cmd_fifo_full & ~bus.wdf_full & ~take;
    end
  end

  // ************************************************************
  // pushes: command and its data leave in the same cycle
  // ************************************************************
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      bus.cmd_fifo_push <= 1'b0;
      bus.cmd_addr_word <= '0;
    end else if (take) begin
      bus.cmd_fifo_push <= 1'b1;
      bus.cmd_addr_word <= {1'b0, USR_CMD, USR_ADDR};
    end else begin
      bus.cmd_fifo_push <= 1'b0;
    end
  end

  // data goes out with the command, well inside the two-cycle limit
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      bus.wdf_push <= 1'b0;
      bus.wdf_data <= '0;
      bus.wdf_mask <= '0;
    end else if (take && USR_CMD == CMD_WRITE) begin
      bus.wdf_push <= 1'b1;
      bus.wdf_data <= USR_WDATA;
      bus.wdf_mask <= USR_WMASK;
    end else begin
      bus.wdf_push <= 1'b0;
    end
  end

  // ************************************************************
  // read return and status
  // ************************************************************
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      cal_q <= 1'b0;
    end else begin
      rvalid_q <= bus.rd_valid;
      cal_q <= bus.calib_done;
      if (bus.rd_valid) begin
        rdata_q <= bus.rd_data;
      end
    end
  end

  assign USR_READY = ready_q;
  assign USR_RDATA = rdata_q;
  assign USR_RVALID = rvalid_q;
  assign USR_CAL_DONE = cal_q;
endmodule
